// [hw/adcc_cfg.svh]
/*
 Register offsets, field positions, reset values and timing counts of the
 converter control block. Assumes a byte-addressed Avalon-MM register port.
*/
`ifndef ADCC_CFG_SVH
`define ADCC_CFG_SVH

// ============================================================
// Register byte offsets
`define ADCC_OFS_CTRL       5'h00
`define ADCC_OFS_CLK        5'h04
`define ADCC_OFS_REF        5'h08
`define ADCC_OFS_DATA_HI    5'h0c
`define ADCC_OFS_DATA_LO    5'h10
`define ADCC_OFS_INT        5'h14

// ============================================================
// Control and interrupt register fields
`define ADCC_CTRL_START     7
`define ADCC_CTRL_BUSY      6
`define ADCC_CTRL_PDOWN     5
`define ADCC_CTRL_CH_HI     2
`define ADCC_INT_GLOBAL     0
`define ADCC_INT_LOCAL      1
`define ADCC_INT_FLAG       2

// ============================================================
// Reset values
`define ADCC_RST_BUSY       1'b1
`define ADCC_RST_PDOWN      1'b1
`define ADCC_RST_CH         3'h0
`define ADCC_RST_CLKSEL     3'h0
`define ADCC_RST_REF        4'h0

// ============================================================
// Timing
`define ADCC_CONV_PERIODS   5'h10

`endif

// [hw/adcc_pkg.sv]
/*
 Types shared by the converter control block.
 Assumes the constants of adcc_cfg.svh are included where needed.
*/
`default_nettype none
package adcc_pkg;

	typedef enum logic [2:0] {
		ADCC_IDLE = 3'b001,
		ADCC_HOLD = 3'b010,
		ADCC_CONV = 3'b100
	} adcc_state_e;

	typedef logic [11:0] adcc_result_t;

endpackage

`default_nettype wire

// [hw/adcc_ctrl.sv]
/*
 Digital control of a 12-bit successive-approximation converter: register
 file on Avalon-MM, start/reset sequencing, clock divider, busy and request
 flags, reference and channel routing. Assumes the analog core samples on
 conv_clk_en_o, and that result_i is stable at the end of a conversion.
*/
// Contract
// R01: High reference follows select field bits 3:2
// R02: Low reference follows select field bits 1:0
// R03: Reference register bits 7:4 read zero
// R04: Software avoids external code on unbonded packages
// R05: Start low-high-low begins one conversion
// R06: Start held high resets core, busy one
// R07: Busy clears when conversion finishes
// R08: Conversion end sets request flag, gated interrupt
// R09: Software sets both enables for interrupt
// R10: Converter clock divided from system clock
// R11: Converter powered only while power-down zero
// R12: Software waits settling after power-up
// R13: Conversion lasts sixteen converter clock periods
// R14: Software starts sequence from start low
// R15: Software reads result after busy low
// R16: Unsigned 12-bit result, full scale ones
// R17: Software powers down when idle
// R18: Clock codes divide by 1 to 64
// R19: Result split high byte, low nibble
// R20: Channel field selects one of eight
// R21: Request flag held until written zero
`timescale 1ns/10ps
`default_nettype none
`include "adcc_cfg.svh"

module adcc_ctrl
	import adcc_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	input  wire logic [4:0]  address_i,
	input  wire logic        read_i,
	input  wire logic        write_i,
	input  wire logic [31:0] writedata_i,
	input  wire logic [3:0]  byteenable_i,
	output logic      [31:0] readdata_o,
	output logic             waitrequest_o,
	input  wire logic [11:0] result_i,
	output logic             conv_reset_o,
	output logic             conv_power_down_o,
	output logic             conv_clk_en_o,
	output logic             conv_sample_o,
	output logic      [2:0]  input_channel_o,
	output logic      [2:0]  high_reference_route_o,
	output logic      [2:0]  low_reference_route_o,
	output logic             irq_o
);

	// ============================================================
	// Functions
	function automatic logic div_tick(input logic [5:0] cnt, input logic [2:0] sel);
		logic [5:0] mask;
		mask = 6'h3f >> (3'h6 - ((sel == 3'h7) ? 3'h6 : sel));
		div_tick = ((cnt & mask) == 6'h00);
	endfunction

	function automatic logic [2:0] ref_route(input logic [1:0] sel);
		ref_route = sel[1] ? 3'h4 : (sel[0] ? 3'h2 : 3'h1);
	endfunction

	// ============================================================
	// State
	adcc_state_e  state_reg;
	logic         start_reg;
	logic         busy_reg;
	logic         pdown_reg;
	logic [2:0]   channel_reg;
	logic [2:0]   clksel_reg;
	logic [1:0]   href_reg;
	logic [1:0]   lref_reg;
	logic         gie_reg;
	logic         lie_reg;
	logic         flag_reg;
	adcc_result_t result_reg;
	adcc_result_t res_meta_reg;
	adcc_result_t res_sync_reg;
	logic [5:0]   div_reg;
	logic [4:0]   tick_cnt_reg;
	logic         waitreq_reg;
	logic [10:0]  conv_cyc_reg;
	logic         sel_moved_reg;

	logic         req;
	logic         wr_go;
	logic         wr_lane;
	logic         tick;
	logic         conv_done;
	logic         start_fall;

	assign req        = read_i | write_i;
	assign wr_go      = write_i & ~waitreq_reg;
	assign wr_lane    = wr_go & byteenable_i[0];
	assign tick       = div_tick(div_reg, clksel_reg);
	assign start_fall = wr_lane && (address_i == `ADCC_OFS_CTRL)
	                    && start_reg && !writedata_i[`ADCC_CTRL_START];
	assign conv_done  = (state_reg == ADCC_CONV) && tick
	                    && (tick_cnt_reg == `ADCC_CONV_PERIODS - 5'h01);

	// ============================================================
	// Bus handshake: one wait cycle, read data latched with it, writes taken after it
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			waitreq_reg <= 1'b1;
		end else begin
			waitreq_reg <= !(req && waitreq_reg);
		end
	end
	assign waitrequest_o = waitreq_reg;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			readdata_o <= 32'h0000_0000;
		end else if (read_i && waitreq_reg) begin
			unique case (address_i)
				`ADCC_OFS_CTRL:    readdata_o <= {24'h0, start_reg, busy_reg, pdown_reg,
				                                 2'b00, channel_reg};
				`ADCC_OFS_CLK:     readdata_o <= {29'h0, clksel_reg};
				`ADCC_OFS_REF:     readdata_o <= {28'h0, href_reg, lref_reg}; // R03
				`ADCC_OFS_DATA_HI: readdata_o <= {24'h0, result_reg[11:4]}; // R19
				`ADCC_OFS_DATA_LO: readdata_o <= {24'h0, result_reg[3:0], 4'h0}; // R19
				`ADCC_OFS_INT:     readdata_o <= {29'h0, flag_reg, lie_reg, gie_reg};
				default:           readdata_o <= 32'h0000_0000;
			endcase
		end
	end

	// ============================================================
	// Software-written configuration
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			start_reg   <= 1'b0;
			pdown_reg   <= `ADCC_RST_PDOWN;
			channel_reg <= `ADCC_RST_CH;
		end else if (wr_lane && address_i == `ADCC_OFS_CTRL) begin
			start_reg   <= writedata_i[`ADCC_CTRL_START];
			pdown_reg   <= writedata_i[`ADCC_CTRL_PDOWN];
			channel_reg <= writedata_i[`ADCC_CTRL_CH_HI:0];
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			clksel_reg <= `ADCC_RST_CLKSEL;
			href_reg   <= 2'(`ADCC_RST_REF >> 2);
			lref_reg   <= 2'(`ADCC_RST_REF);
			gie_reg    <= 1'b0;
			lie_reg    <= 1'b0;
		end else if (wr_lane) begin
			if (address_i == `ADCC_OFS_CLK) begin
				clksel_reg <= writedata_i[2:0];
			end
			if (address_i == `ADCC_OFS_REF) begin
				href_reg <= writedata_i[3:2];
				lref_reg <= writedata_i[1:0];
			end
			if (address_i == `ADCC_OFS_INT) begin
				gie_reg <= writedata_i[`ADCC_INT_GLOBAL];
				lie_reg <= writedata_i[`ADCC_INT_LOCAL];
			end
		end
	end

	// ============================================================
	// Conversion sequencing
	// Divider restarts on the start fall so period one is a full period
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			div_reg <= 6'h00;
		end else if (start_fall) begin
			div_reg <= 6'h01;
		end else begin
			div_reg <= div_reg + 6'h01; // R10 R18
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_reg    <= ADCC_IDLE;
			tick_cnt_reg <= 5'h00;
		end else if (pdown_reg) begin
			state_reg    <= ADCC_IDLE; // R11
			tick_cnt_reg <= 5'h00;
		end else begin
			unique case (state_reg)
				ADCC_IDLE, ADCC_CONV: begin
					if (start_reg) begin
						state_reg <= ADCC_HOLD; // R06
					end else if (conv_done) begin
						state_reg <= ADCC_IDLE; // R13
					end
					if (state_reg == ADCC_CONV && tick) begin
						tick_cnt_reg <= tick_cnt_reg + 5'h01;
					end
				end
				ADCC_HOLD: begin
					tick_cnt_reg <= 5'h00;
					if (start_fall) begin
						state_reg <= ADCC_CONV; // R05
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			conv_cyc_reg  <= 11'h000;
			sel_moved_reg <= 1'b0;
		end else begin
			conv_cyc_reg  <= (state_reg == ADCC_CONV) ? conv_cyc_reg + 11'h001 : 11'h000;
			sel_moved_reg <= !start_fall
			                 && (sel_moved_reg || (wr_lane && address_i == `ADCC_OFS_CLK));
		end
	end

	// Busy stays high after an abort by power-down: no result was made
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			busy_reg <= `ADCC_RST_BUSY;
		end else if (start_reg) begin
			busy_reg <= 1'b1; // R06
		end else if (conv_done && !pdown_reg) begin
			busy_reg <= 1'b0; // R07
		end
	end

	// Analog result is asynchronous to clk_i
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			res_meta_reg <= 12'h000;
			res_sync_reg <= 12'h000;
			result_reg   <= 12'h000;
		end else begin
			res_meta_reg <= result_i;
			res_sync_reg <= res_meta_reg;
			if (conv_done && !pdown_reg) begin
				result_reg <= res_sync_reg; // R16
			end
		end
	end

	// Set wins over a software clear in the same cycle
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			flag_reg <= 1'b0;
		end else if (conv_done && !pdown_reg) begin
			flag_reg <= 1'b1; // R08
		end else if (wr_lane && address_i == `ADCC_OFS_INT
		             && !writedata_i[`ADCC_INT_FLAG]) begin
			flag_reg <= 1'b0; // R21
		end
	end

	// ============================================================
	// Outputs toward the analog side and the interrupt line
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			conv_reset_o           <= 1'b1;
			conv_power_down_o      <= 1'b1;
			conv_clk_en_o          <= 1'b0;
			conv_sample_o          <= 1'b0;
			input_channel_o        <= 3'h0;
			high_reference_route_o <= 3'h1;
			low_reference_route_o  <= 3'h1;
			irq_o                  <= 1'b0;
		end else begin
			conv_reset_o           <= (state_reg != ADCC_CONV); // R06
			conv_power_down_o      <= pdown_reg; // R11
			conv_clk_en_o          <= tick && (state_reg == ADCC_CONV); // R10
			conv_sample_o          <= conv_done;
			input_channel_o        <= channel_reg; // R20
			high_reference_route_o <= ref_route(href_reg); // R01
			low_reference_route_o  <= ref_route(lref_reg); // R02
			irq_o                  <= flag_reg && gie_reg && lie_reg; // R08 R09
		end
	end

	// ============================================================
	// Checks
	sequence s_fall_from_hold;
		state_reg == ADCC_HOLD && start_fall && !pdown_reg;
	endsequence

	sequence s_finish;
		conv_done && !pdown_reg && !start_reg;
	endsequence

	chk_hold_reset: assert property (@(posedge clk_i) disable iff (!rstn_i) // R06
		start_reg && !start_fall |=> busy_reg ##1 conv_reset_o)
		else $error("start high did not hold converter in reset");

	chk_start_seq: assert property (@(posedge clk_i) disable iff (!rstn_i) // R05
		s_fall_from_hold |=> state_reg == ADCC_CONV && busy_reg)
		else $error("start fall did not begin conversion");

	chk_conv_length: assert property (@(posedge clk_i) disable iff (!rstn_i) // R13
		s_finish && !sel_moved_reg |-> conv_cyc_reg + 11'h001 ==
		({6'h00, `ADCC_CONV_PERIODS} << ((clksel_reg == 3'h7) ? 3'h6 : clksel_reg)))
		else $error("conversion did not last sixteen periods");

	chk_busy_flag: assert property (@(posedge clk_i) disable iff (!rstn_i) // R07
		s_finish |=> !busy_reg && flag_reg && state_reg == ADCC_IDLE)
		else $error("busy not cleared or flag not set at end");

	chk_irq_gate: assert property (@(posedge clk_i) disable iff (!rstn_i) // R08
		irq_o == $past(flag_reg && gie_reg && lie_reg))
		else $error("interrupt not gated by both enables");

	chk_flag_hold: assert property (@(posedge clk_i) disable iff (!rstn_i) // R21
		flag_reg && !(wr_lane && address_i == `ADCC_OFS_INT) |=> flag_reg)
		else $error("request flag dropped without a write");

	chk_ref_route: assert property (@(posedge clk_i) disable iff (!rstn_i) // R01
		##1 high_reference_route_o == (href_reg[1] ? 3'h4 : {1'b0, href_reg[0], !href_reg[0]})
		    || $changed(href_reg))
		else $error("high reference route wrong");

	chk_low_route: assert property (@(posedge clk_i) disable iff (!rstn_i) // R02
		$stable(lref_reg) && lref_reg == 2'b01 |=> low_reference_route_o == 3'h2)
		else $error("low reference route wrong");

	chk_ref_read: assert property (@(posedge clk_i) disable iff (!rstn_i) // R03
		read_i && waitreq_reg && address_i == `ADCC_OFS_REF |=> readdata_o[31:4] == 28'h0)
		else $error("reference register upper bits not zero");

	chk_power_off: assert property (@(posedge clk_i) disable iff (!rstn_i) // R11
		pdown_reg |=> state_reg == ADCC_IDLE && conv_power_down_o)
		else $error("converter not off under power-down");

endmodule

`default_nettype wire

// [testbench/adcc_core_model.sv]
/*
 Analog core stand-in: returns a result coded from the selected channel.
 Assumes the control block holds the channel steady while converting.
*/
`timescale 1ns/10ps
`default_nettype none
module adcc_core_model (
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	input  wire logic        hold_i,
	input  wire logic        off_i,
	input  wire logic [2:0]  ch_i,
	output logic      [11:0] result_o
);
	// ========
	// Result
	// Idle output churns so a stale sample cannot pass
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i)
			result_o <= 12'h000;
		else if (hold_i || off_i)
			result_o <= ~result_o;
		else
			result_o <= {ch_i, ch_i, ch_i, ch_i};
	end
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
/*
 Self-checking bench for adcc_ctrl with the analog core model.
 Assumes byte-lane-0 registers behind an Avalon-MM port.
*/
`timescale 1ns/10ps
`default_nettype none
`include "adcc_cfg.svh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin failures++; \
	$display("[ERR] %0t got %h exp %h", $time, a, e); end end
module tb_top;
	typedef struct {logic [2:0] k; logic [3:0] r; logic [2:0] h, l; int s;} adcc_row_s;
	localparam logic [4:0] ctl = `ADCC_OFS_CTRL;
	localparam logic [4:0] ckr = `ADCC_OFS_CLK;
	localparam logic [4:0] rfr = `ADCC_OFS_REF;
	localparam logic [4:0] irr = `ADCC_OFS_INT;
	logic        clk_i = 1'b0, rstn_i = 1'b0, read_i = 1'b0, write_i = 1'b0;
	logic [4:0]  address_i = 5'h00;
	logic [31:0] writedata_i = 32'h0, readdata_o, rdat;
	logic [3:0]  byteenable_i = 4'h1;
	logic        waitrequest_o, conv_reset_o, conv_power_down_o, conv_clk_en_o;
	logic        conv_sample_o, irq_o;
	logic [11:0] result_i;
	logic [2:0]  input_channel_o, high_reference_route_o, low_reference_route_o;
	int          failures = 0, samples_checked = 0, span = 0, got = 0, ens = 0, gotens = 0;
	// Inputs k (clock code, channel), r; outputs routes h, l and run length s
	adcc_row_s   rows [8] = '{
		'{3'h0, 4'h0, 3'h1, 3'h1, 16}, '{3'h1, 4'h5, 3'h2, 3'h2, 32},
		'{3'h2, 4'ha, 3'h4, 3'h4, 64}, '{3'h3, 4'hf, 3'h4, 3'h4, 128},
		'{3'h4, 4'h4, 3'h2, 3'h1, 256}, '{3'h5, 4'h9, 3'h4, 3'h2, 512},
		'{3'h6, 4'he, 3'h4, 3'h4, 1024}, '{3'h7, 4'h3, 3'h1, 3'h4, 1024}};

	always #4 clk_i = ~clk_i;

	adcc_ctrl adcc_ctrl_i (.clk_i, .rstn_i, .address_i, .read_i, .write_i, .writedata_i,
		.byteenable_i, .readdata_o, .waitrequest_o, .result_i, .conv_reset_o,
		.conv_power_down_o, .conv_clk_en_o, .conv_sample_o, .input_channel_o,
		.high_reference_route_o, .low_reference_route_o, .irq_o);
	adcc_core_model adcc_core_model_i (.clk_i, .rstn_i, .hold_i(conv_reset_o),
		.off_i(conv_power_down_o), .ch_i(input_channel_o), .result_o(result_i));

	// ========
	// Run length from core release to sample pulse
	// Counts cycles and enable pulses while the core is out of reset
	always @(posedge clk_i) begin
		span <= conv_reset_o ? 0 : span + 1;
		ens <= conv_reset_o ? 0 : ens + int'(conv_clk_en_o);
		if (conv_sample_o) begin
			got <= span + 1;
			gotens <= ens + int'(conv_clk_en_o);
		end
	end

	// ========
	// Tasks
	task automatic bus(input logic [4:0] a, input logic w, input logic [7:0] d);
		@(posedge clk_i);
		address_i <= a;
		write_i <= w;
		read_i <= !w;
		writedata_i <= {24'h000000, d};
		// Only the watchdog ends a wait for the answer
		do begin
			@(posedge clk_i);
		end while (waitrequest_o !== 1'b0);
		rdat = readdata_o;
		write_i <= 1'b0;
		read_i <= 1'b0;
	endtask

	task automatic run(input logic [2:0] ch);
		bus(ctl, 1'b1, {5'h00, ch});
		// Settling time after power-up before any start
		repeat (8) @(posedge clk_i);
		bus(ctl, 1'b1, {5'h10, ch});
		bus(ctl, 1'b1, {5'h00, ch});
		do begin
			bus(ctl, 1'b0, 8'h00);
		end while (rdat[6] !== 1'b0);
	endtask

	task give_verdict;
		$display("failures=%0d samples_checked=%0d", failures, samples_checked);
		if (failures == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		repeat (30000) @(posedge clk_i);
		failures++;
		give_verdict();
	end

	// ========
	// Sequence
	initial begin
		repeat (6) @(posedge clk_i);
		rstn_i <= 1'b1;
		foreach (rows[i]) begin
			bus(ckr, 1'b1, {5'h00, rows[i].k});
			bus(rfr, 1'b1, {4'hf, rows[i].r});
			run(rows[i].k);
			`CHK(rdat[7:0], {5'h00, rows[i].k})
			`CHK(got, rows[i].s)
			`CHK(gotens, `ADCC_CONV_PERIODS)
			`CHK(high_reference_route_o, rows[i].h)
			`CHK(low_reference_route_o, rows[i].l)
			`CHK(input_channel_o, rows[i].k)
			bus(rfr, 1'b0, 8'h00);
			`CHK(rdat, {28'h0, rows[i].r})
			bus(`ADCC_OFS_DATA_HI, 1'b0, 8'h00);
			`CHK(rdat, {24'h0, rows[i].k, rows[i].k, rows[i].k[2:1]})
			bus(`ADCC_OFS_DATA_LO, 1'b0, 8'h00);
			`CHK(rdat, {24'h0, rows[i].k[0], rows[i].k, 4'h0})
			bus(irr, 1'b0, 8'h00);
			`CHK(rdat[2], 1'b1)
			bus(ctl, 1'b1, {5'h04, rows[i].k});
		end
		// Global enable alone must not raise the line
		bus(irr, 1'b1, 8'h01);
		run(3'h2);
		repeat (2) @(posedge clk_i);
		`CHK(irq_o, 1'b0)
		bus(irr, 1'b0, 8'h00);
		`CHK(rdat, 32'h5)
		bus(irr, 1'b1, 8'h07);
		repeat (2) @(posedge clk_i);
		`CHK(irq_o, 1'b1)
		bus(irr, 1'b1, 8'h03);
		repeat (2) @(posedge clk_i);
		`CHK(irq_o, 1'b0)
		// Power-down in mid conversion
		bus(ctl, 1'b1, 8'h80);
		bus(ctl, 1'b1, 8'h00);
		repeat (20) @(posedge clk_i);
		bus(ctl, 1'b1, 8'h20);
		repeat (2) @(posedge clk_i);
		`CHK(conv_power_down_o, 1'b1)
		bus(ctl, 1'b0, 8'h00);
		`CHK(rdat, 32'h60)
		bus(irr, 1'b0, 8'h00);
		`CHK(rdat[2], 1'b0)
		bus(ctl, 1'b1, 8'h80);
		repeat (2) @(posedge clk_i);
		`CHK(conv_reset_o, 1'b1)
		bus(ctl, 1'b0, 8'h00);
		`CHK(rdat, 32'hc0)
		// Start fall while powered down is refused
		bus(ctl, 1'b1, 8'ha0);
		bus(ctl, 1'b1, 8'h20);
		repeat (40) @(posedge clk_i);
		`CHK(conv_reset_o, 1'b1)
		bus(ctl, 1'b0, 8'h00);
		`CHK(rdat, 32'h60)
		byteenable_i <= 4'h0;
		bus(rfr, 1'b1, 8'h0c);
		byteenable_i <= 4'h1;
		bus(rfr, 1'b0, 8'h00);
		`CHK(rdat, 32'h3)
		bus(5'h18, 1'b0, 8'h00);
		`CHK(rdat, 32'h0)
		// Second reset in mid run
		rstn_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		`CHK(conv_reset_o, 1'b1)
		`CHK(high_reference_route_o, 3'h1)
		`CHK(low_reference_route_o, 3'h1)
		`CHK(irq_o, 1'b0)
		rstn_i <= 1'b1;
		bus(ctl, 1'b0, 8'h00);
		`CHK(rdat, 32'h60)
		bus(ckr, 1'b0, 8'h00);
		`CHK(rdat, 32'h0)
		bus(rfr, 1'b0, 8'h00);
		`CHK(rdat, 32'h0)
		give_verdict();
	end
endmodule
`default_nettype wire
